// ### design/l1dc_cache.sv
`timescale 1ns/10ps
// Function
// - Cache is two-way set associative; an address lives in one of two slots.
// - Dirty lines go to lower memory only on victim eviction or software write-back.
// - Non-CPU requests arrive only via the slave DMA port of the access controller.
// - Slave DMA writes to level-two SRAM lines held here start snoop writes.
// - Two CPU reads per cycle accepted; each may allocate a replacement line.
// - Read allocating a slot with pending snoop cancels it, evicts, fills new data.
// - Snoop never completes into a slot refilled from a different address.
// - Snoop updates only clean lines previously read from level-two SRAM.
module l1dc_cache import l1dc_pkg::*; #(
   parameter int SETW = SET_W,
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // CPU read port A and B, fill data supplied with the request
   input wire logic rdValidA,
   input wire logic [AW-1:0] rdAddrA,
   input wire logic [1:0] rdSrcA,
   input wire logic [DW-1:0] rdFillA,
   input wire logic rdValidB,
   input wire logic [AW-1:0] rdAddrB,
   input wire logic [1:0] rdSrcB,
   input wire logic [DW-1:0] rdFillB,
   output logic rdHitA,
   output logic rdHitB,
   output logic [DW-1:0] rdDataA,
   output logic [DW-1:0] rdDataB,
   // CPU write (marks hit line dirty)
   input wire logic wrValid,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [DW-1:0] wrData,
   // Software write-back request
   input wire logic wbReq,
   input wire logic [AW-1:0] wbAddr,
   // Slave DMA port write into level-two SRAM
   input wire logic slaveDmaValid,
   input wire logic [AW-1:0] slaveDmaAddr,
   input wire logic [DW-1:0] slaveDmaData,
   output logic slaveDmaReady,
   // Write-back to level-two memory
   output logic wbValid,
   output logic [AW-1:0] wbOutAddr,
   output logic [DW-1:0] wbOutData,
   // Snoop result
   output logic snoopDone,
   output logic snoopDropped
);
   localparam int TAGW = AW - SETW - OFF_W;
   localparam int SETS = 1 << SETW;
   localparam logic [1:0] LAT = 2'(SNOOP_LAT - 1);

   // ==========================================================
   // Storage
   logic [TAGW-1:0] tagMem [WAYS][SETS];
   logic [DW-1:0] dataMem [WAYS][SETS];
   logic valid [WAYS][SETS];
   logic dirty [WAYS][SETS];
   logic fromSram [WAYS][SETS];
   logic lru [SETS];

   function automatic logic [SETW-1:0] setOf(input logic [AW-1:0] a);
      return a[OFF_W +: SETW];
   endfunction
   function automatic logic [TAGW-1:0] tagOf(input logic [AW-1:0] a);
      return a[AW-1 -: TAGW];
   endfunction
   // Way holding the address, bit 1 flags a hit
   function automatic logic [1:0] lookup(input logic [AW-1:0] a,
                                         input logic [TAGW-1:0] t0, input logic v0,
                                         input logic [TAGW-1:0] t1, input logic v1);
      if (v0 && t0 == tagOf(a)) begin
         return 2'b10;
      end
      if (v1 && t1 == tagOf(a)) begin
         return 2'b11;
      end
      return 2'b00;
   endfunction

   // ==========================================================
   // Lookup and victim choice
   logic [1:0] hitA, hitB, hitW, hitWb, hitSn;
   logic [SETW-1:0] setA, setB, setW, setWb, setSn;
   logic vicA, vicB;
   logic allocA, allocB;

   assign setA = setOf(rdAddrA);
   assign setB = setOf(rdAddrB);
   assign setW = setOf(wrAddr);
   assign setWb = setOf(wbAddr);
   assign hitA = lookup(rdAddrA, tagMem[0][setA], valid[0][setA], tagMem[1][setA], valid[1][setA]);
   assign hitB = lookup(rdAddrB, tagMem[0][setB], valid[0][setB], tagMem[1][setB], valid[1][setB]);
   assign hitW = lookup(wrAddr, tagMem[0][setW], valid[0][setW], tagMem[1][setW], valid[1][setW]);
   assign hitWb = lookup(wbAddr, tagMem[0][setWb], valid[0][setWb], tagMem[1][setWb], valid[1][setWb]);
   assign allocA = rdValidA && !hitA[1];
   assign allocB = rdValidB && !hitB[1];
   assign vicA = lru[setA];
   // Two misses to one set take both ways rather than colliding
   assign vicB = (allocA && setA == setB) ? !lru[setB] : lru[setB];

   // ==========================================================
   // Snoop engine: one snoop in flight, slot captured at start
   l1dc_snst_t snState;
   logic [SETW-1:0] snSet;
   logic snWay;
   logic [TAGW-1:0] snTag;
   logic [DW-1:0] snData;
   logic [1:0] snCnt;
   logic snKill;

   assign setSn = setOf(slaveDmaAddr);
   assign hitSn = lookup(slaveDmaAddr, tagMem[0][setSn], valid[0][setSn], tagMem[1][setSn], valid[1][setSn]);
   assign slaveDmaReady = (snState == L1DC_SN_IDLE);
   // Refill of the snoop slot, same cycle as a pending snoop, cancels it
   assign snKill = (allocA && setA == snSet && vicA == snWay) ||
                   (allocB && setB == snSet && vicB == snWay);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         snState <= L1DC_SN_IDLE;
         snSet <= '0;
         snWay <= 1'b0;
         snTag <= '0;
         snData <= '0;
         snCnt <= 2'h0;
         snoopDone <= 1'b0;
         snoopDropped <= 1'b0;
      end else begin
         snoopDone <= 1'b0;
         snoopDropped <= 1'b0;
         case (snState)
            L1DC_SN_IDLE: begin
               if (slaveDmaValid) begin
                  // Only clean level-two SRAM lines take the update
                  if (hitSn[1] && fromSram[hitSn[0]][setSn] && !dirty[hitSn[0]][setSn]) begin
                     snState <= L1DC_SN_WAIT;
                     snSet <= setSn;
                     snWay <= hitSn[0];
                     snTag <= tagOf(slaveDmaAddr);
                     snData <= slaveDmaData;
                     snCnt <= LAT;
                  end else begin
                     snoopDropped <= 1'b1;
                  end
               end
            end
            L1DC_SN_WAIT: begin
               if (snKill) begin
                  snState <= L1DC_SN_IDLE;
                  snoopDropped <= 1'b1;
               end else if (snCnt == 2'h0) begin
                  snState <= L1DC_SN_DONE;
               end else begin
                  snCnt <= snCnt - 2'h1;
               end
            end
            L1DC_SN_DONE: begin
               snState <= L1DC_SN_IDLE;
               snoopDone <= 1'b1;
            end
            default: snState <= L1DC_SN_IDLE;
         endcase
      end
   end

   // Final write guarded by tag recheck as a second line of defence
   logic snCommit;
   // A CPU write during the wait makes the line dirty; the snoop must not clobber it
   assign snCommit = (snState == L1DC_SN_DONE) && valid[snWay][snSet] && !dirty[snWay][snSet] &&
                     tagMem[snWay][snSet] == snTag;

   // ==========================================================
   // Array update
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int s = 0; s < SETS; s++) begin
            for (int w = 0; w < WAYS; w++) begin
               tagMem[w][s] <= '0;
               dataMem[w][s] <= '0;
               valid[w][s] <= 1'b0;
               dirty[w][s] <= 1'b0;
               fromSram[w][s] <= 1'b0;
            end
            lru[s] <= 1'b0;
         end
      end else begin
         // Clear first so a CPU write in the same cycle leaves the line dirty
         if (wbReq && hitWb[1]) begin
            dirty[hitWb[0]][setWb] <= 1'b0;
         end
         if (snCommit) begin
            dataMem[snWay][snSet] <= snData;
         end
         if (wrValid && hitW[1]) begin
            dataMem[hitW[0]][setW] <= wrData;
            dirty[hitW[0]][setW] <= 1'b1;
            lru[setW] <= !hitW[0];
         end
         if (rdValidA) begin
            if (allocA) begin
               tagMem[vicA][setA] <= tagOf(rdAddrA);
               dataMem[vicA][setA] <= rdFillA;
               valid[vicA][setA] <= 1'b1;
               dirty[vicA][setA] <= 1'b0;
               fromSram[vicA][setA] <= (rdSrcA == 2'(L1DC_SRC_L2SRAM));
               lru[setA] <= !vicA;
            end else begin
               lru[setA] <= !hitA[0];
            end
         end
         if (rdValidB) begin
            if (allocB) begin
               tagMem[vicB][setB] <= tagOf(rdAddrB);
               dataMem[vicB][setB] <= rdFillB;
               valid[vicB][setB] <= 1'b1;
               dirty[vicB][setB] <= 1'b0;
               fromSram[vicB][setB] <= (rdSrcB == 2'(L1DC_SRC_L2SRAM));
               lru[setB] <= !vicB;
            end else begin
               lru[setB] <= !hitB[0];
            end
         end
      end
   end

   // ==========================================================
   // Read data and write-back output
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdHitA <= 1'b0;
         rdHitB <= 1'b0;
         rdDataA <= '0;
         rdDataB <= '0;
      end else begin
         rdHitA <= rdValidA && hitA[1];
         rdHitB <= rdValidB && hitB[1];
         rdDataA <= hitA[1] ? dataMem[hitA[0]][setA] : rdFillA;
         rdDataB <= hitB[1] ? dataMem[hitB[0]][setB] : rdFillB;
      end
   end

   // Port A takes priority for a victim write-back; a same-cycle B victim is
   // also dirty-checked but only one leaves per cycle, so A wins the port.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wbValid <= 1'b0;
         wbOutAddr <= '0;
         wbOutData <= '0;
      end else begin
         wbValid <= 1'b0;
         if (wbReq && hitWb[1] && dirty[hitWb[0]][setWb]) begin
            wbValid <= 1'b1;
            wbOutAddr <= wbAddr;
            wbOutData <= dataMem[hitWb[0]][setWb];
         end else if (allocA && valid[vicA][setA] && dirty[vicA][setA]) begin
            wbValid <= 1'b1;
            wbOutAddr <= {tagMem[vicA][setA], setA, OFF_W'(0)};
            wbOutData <= dataMem[vicA][setA];
         end else if (allocB && valid[vicB][setB] && dirty[vicB][setB]) begin
            wbValid <= 1'b1;
            wbOutAddr <= {tagMem[vicB][setB], setB, OFF_W'(0)};
            wbOutData <= dataMem[vicB][setB];
         end
      end
   end
endmodule

// ### design/l1dc_pkg.sv
package l1dc_pkg;
   // Geometry defaults
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int SET_W = 4;
   localparam int OFF_W = 2;
   localparam int WAYS = 2;
   // Snoop pipeline length; the write into the array lands SNOOP_LAT+1 cycles after acceptance
   localparam int SNOOP_LAT = 2;
   // Memory target of a CPU read
   typedef enum logic [1:0] {
      L1DC_SRC_L2CACHE = 2'b00,
      L1DC_SRC_L2SRAM = 2'b01,
      L1DC_SRC_EXT = 2'b10
   } l1dc_src_t;
   // Snoop engine state
   typedef enum logic [1:0] {
      L1DC_SN_IDLE = 2'b00,
      L1DC_SN_WAIT = 2'b01,
      L1DC_SN_DONE = 2'b10
   } l1dc_snst_t;
endpackage

// ### tb/l1dc_cache_assertions.sv
`timescale 1ns/10ps
// ====
// Read, write-back and snoop checks at the cache ports
module l1dc_cache_assertions #(
   parameter int DW = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic rdValidA,
   input wire logic rdValidB,
   input wire logic [DW-1:0] rdFillA,
   input wire logic [DW-1:0] rdFillB,
   input wire logic rdHitA,
   input wire logic rdHitB,
   input wire logic [DW-1:0] rdDataA,
   input wire logic [DW-1:0] rdDataB,
   input wire logic wbReq,
   input wire logic wbValid,
   input wire logic slaveDmaValid,
   input wire logic slaveDmaReady,
   input wire logic snoopDone,
   input wire logic snoopDropped
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_miss_fill_a: assert property (rdValidA |=> rdHitA || rdDataA == $past(rdFillA))
      else $error("port A miss did not return fill data");
   a_miss_fill_b: assert property (rdValidB |=> rdHitB || rdDataB == $past(rdFillB))
      else $error("port B miss did not return fill data");
   a_hit_cause: assert property (rdHitA |-> $past(rdValidA))
      else $error("hit without a read");
   a_wb_cause: assert property (wbValid |-> $past(wbReq) || $past(rdValidA) || $past(rdValidB))
      else $error("write-back without eviction or request");
   a_done_timing: assert property (snoopDone |-> $past(slaveDmaReady) == 1'b0 && $past(slaveDmaReady, 3) == 1'b0)
      else $error("snoop completed off schedule");
   a_ready_bound: assert property (!slaveDmaReady |-> ##[1:3] slaveDmaReady)
      else $error("snoop held the port too long");
   a_drop_absent: assert property (slaveDmaValid && slaveDmaReady |=> snoopDropped || !slaveDmaReady)
      else $error("accepted snoop neither pending nor dropped");
   a_done_excl: assert property (!(snoopDone && snoopDropped))
      else $error("snoop both completed and dropped");
endmodule

// ### tb/l1dc_dma_model.sv
`timescale 1ns/10ps
// ====
// External bus master behind the slave DMA port
module l1dc_dma_model (
   // Clock
   input wire logic ref_clk,
   // Slave DMA write
   output logic slaveDmaValid,
   output logic [31:0] slaveDmaAddr,
   output logic [31:0] slaveDmaData,
   input wire logic slaveDmaReady
);
   initial begin
      slaveDmaValid = 1'b0;
      slaveDmaAddr = 32'h0;
      slaveDmaData = 32'h0;
   end
   // Called at a falling edge; holds the request until ready is sampled high, giving up after 8 rising edges
   task automatic send(input logic [31:0] a, input logic [31:0] d, output bit ok);
      ok = 1'b0;
      slaveDmaValid = 1'b1;
      slaveDmaAddr = a;
      slaveDmaData = d;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge ref_clk);
         ok = slaveDmaReady;
      end
      @(negedge ref_clk);
      slaveDmaValid = 1'b0;
      // Released lines flip so no stale value can pass for a match
      slaveDmaAddr = ~a;
      slaveDmaData = ~d;
   endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic ref_clk, rst, rdValidA, rdValidB, rdHitA, rdHitB, wrValid, wbReq, wbValid;
   logic slaveDmaValid, slaveDmaReady, snoopDone, snoopDropped;
   logic [1:0] rdSrcA, rdSrcB;
   logic [31:0] rdAddrA, rdFillA, rdAddrB, rdFillB, rdDataA, rdDataB, wrAddr, wrData, wbAddr;
   logic [31:0] slaveDmaAddr, slaveDmaData, wbOutAddr, wbOutData;
   int errors, comparisons, nDone, nDrop, nWb;
   bit ok;
   l1dc_cache dut_u (.ref_clk, .rst, .rdValidA, .rdAddrA, .rdSrcA, .rdFillA, .rdValidB, .rdAddrB, .rdSrcB,
      .rdFillB, .rdHitA, .rdHitB, .rdDataA, .rdDataB, .wrValid, .wrAddr, .wrData, .wbReq, .wbAddr,
      .slaveDmaValid, .slaveDmaAddr, .slaveDmaData, .slaveDmaReady, .wbValid, .wbOutAddr, .wbOutData,
      .snoopDone, .snoopDropped);
   l1dc_dma_model dma_u (.ref_clk, .slaveDmaValid, .slaveDmaAddr, .slaveDmaData, .slaveDmaReady);
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (snoopDone === 1'b1) nDone++;
      if (snoopDropped === 1'b1) nDrop++;
      if (wbValid === 1'b1) nWb++;
   end
   // ====
   // Shared helpers
   function automatic logic [31:0] ad(input logic [25:0] t, input logic [3:0] s);
      return {t, s, 2'b00};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic rd(input logic [31:0] aa, fa, input logic [1:0] sa, input logic vb, input logic [31:0] ab, fb);
      rdValidA = 1'b1;
      rdAddrA = aa;
      rdFillA = fa;
      rdSrcA = sa;
      rdValidB = vb;
      rdAddrB = ab;
      rdFillB = fb;
      @(negedge ref_clk);
      rdValidA = 1'b0;
      rdValidB = 1'b0;
   endtask
   task automatic snoop(input logic [31:0] a, d);
      nDone = 0;
      nDrop = 0;
      dma_u.send(a, d, ok);
      if (!ok) begin
         errors++;
         tally_and_finish();
      end
   endtask
   task automatic settle(input int expDone, expDrop);
      repeat (6) @(negedge ref_clk);
      chk(nDone, expDone);
      chk(nDrop, expDrop);
   endtask
   // ====
   // Scenarios
   task automatic t_fill;
      rd(ad(1, 3), 32'h11, 2'b01, 1'b0, 32'h0, 32'h0);
      chk(rdHitA, 1'b0);
      chk(rdDataA, 32'h11);
      @(negedge ref_clk);
      rd(ad(2, 3), 32'h22, 2'b01, 1'b0, 32'h0, 32'h0);
      @(negedge ref_clk);
      rd(ad(1, 3), 32'hee, 2'b01, 1'b0, 32'h0, 32'h0);
      chk(rdHitA, 1'b1);
      chk(rdDataA, 32'h11);
   endtask
   task automatic t_snoop;
      snoop(ad(1, 3), 32'hd1);
      settle(1, 0);
      rd(ad(1, 3), 32'hee, 2'b01, 1'b0, 32'h0, 32'h0);
      chk(rdDataA, 32'hd1);
      snoop(ad(9, 7), 32'hd2);
      settle(0, 1);
      rd(ad(3, 5), 32'h35, 2'b00, 1'b0, 32'h0, 32'h0);
      snoop(ad(3, 5), 32'hd3);
      settle(0, 1);
   endtask
   task automatic t_dirty;
      wrValid = 1'b1;
      wrAddr = ad(2, 3);
      wrData = 32'h77;
      @(negedge ref_clk);
      wrValid = 1'b0;
      snoop(ad(2, 3), 32'hd4);
      settle(0, 1);
      chk(nWb, 0);
      wbReq = 1'b1;
      wbAddr = ad(2, 3);
      @(negedge ref_clk);
      wbReq = 1'b0;
      @(negedge ref_clk);
      chk(nWb, 1);
      chk(wbOutAddr, ad(2, 3));
      chk(wbOutData, 32'h77);
   endtask
   // Both reads land while the snoop waits, so the snoop's way is surely refilled
   task automatic t_cancel;
      snoop(ad(1, 3), 32'hd5);
      rdSrcB = 2'b01;
      rd(ad(5, 3), 32'h55, 2'b00, 1'b1, ad(6, 3), 32'h66);
      settle(0, 1);
      rd(ad(5, 3), 32'hee, 2'b00, 1'b0, 32'h0, 32'h0);
      chk(rdDataA, 32'h55);
      @(negedge ref_clk);
      rd(ad(6, 3), 32'hee, 2'b00, 1'b1, ad(5, 3), 32'hee);
      chk(rdDataA, 32'h66);
      chk(rdHitB, 1'b1);
      chk(rdDataB, 32'h55);
      // Line filled through port B from level-two SRAM takes a snoop
      snoop(ad(6, 3), 32'hd6);
      settle(1, 0);
      rd(ad(6, 3), 32'hee, 2'b00, 1'b0, 32'h0, 32'h0);
      chk(rdDataA, 32'hd6);
   endtask
   // Dirty way is least recently used, so the next miss evicts it
   task automatic t_victim;
      wrValid = 1'b1;
      wrAddr = ad(6, 3);
      wrData = 32'h88;
      @(negedge ref_clk);
      wrValid = 1'b0;
      rd(ad(5, 3), 32'hee, 2'b00, 1'b0, 32'h0, 32'h0);
      chk(rdHitA, 1'b1);
      nWb = 0;
      @(negedge ref_clk);
      rd(ad(7, 3), 32'h79, 2'b00, 1'b0, 32'h0, 32'h0);
      @(negedge ref_clk);
      chk(nWb, 1);
      chk(wbOutAddr, ad(6, 3));
      chk(wbOutData, 32'h88);
   endtask
   initial begin
      rst = 1'b1;
      rdValidA = 1'b0;
      rdValidB = 1'b0;
      rdSrcA = 2'b00;
      rdSrcB = 2'b00;
      {rdAddrA, rdFillA, rdAddrB, rdFillB, wrAddr, wrData, wbAddr} = '0;
      wrValid = 1'b0;
      wbReq = 1'b0;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      t_fill();
      t_snoop();
      t_dirty();
      t_cancel();
      t_victim();
      tally_and_finish();
   end
endmodule
bind l1dc_cache l1dc_cache_assertions #(.DW(DW)) chk_u (.ref_clk, .rst, .rdValidA, .rdValidB, .rdFillA, .rdFillB,
   .rdHitA, .rdHitB, .rdDataA, .rdDataB, .wbReq, .wbValid, .slaveDmaValid, .slaveDmaReady, .snoopDone, .snoopDropped);
